/* File: dsc_pkg.sv */
package dsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS      = 8;
  localparam int MS_NS       = 1000000;
  localparam int MS_CYC      = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int KEY_HOLD_MS = 2000;
  localparam int CTL_MIN_MS  = 500;
  localparam int CTL_MAX_MS  = 4000;
  localparam int CTL_RST_MS  = 5000;
  localparam int BLINK_MS    = 500;
  localparam int DS_MS       = 100;
  localparam logic [13:0] MS_SAT = 14'h3fff;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [4:0] A_CTRL  = 5'h00;
  localparam logic [4:0] A_QTY   = 5'h04;
  localparam logic [4:0] A_UNIT  = 5'h08;
  localparam logic [4:0] A_CORR  = 5'h0c;
  localparam logic [4:0] A_TMO   = 5'h10;
  localparam logic [4:0] A_COUNT = 5'h14;
  localparam logic [4:0] A_STAT  = 5'h18;

  // Control bits
  localparam int CTRL_DOS  = 0;
  localparam int CTRL_O1EN = 1;
  localparam int CTRL_O1LV = 2;
  localparam int CTRL_O2EN = 3;
  localparam int CTRL_O2LV = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Settings, quantity and correction in tenths of a unit
  localparam logic [16:0] QTY_MAX = 17'h1869f;
  localparam logic [16:0] QTY_RST = 17'h00064;
  localparam logic [18:0] CORR_RST = 19'h00000;
  localparam logic [6:0] TMO_MIN = 7'h05;
  localparam logic [6:0] TMO_MAX = 7'h64;
  localparam logic [6:0] TMO_RST = 7'h0a;

  // Status flag positions
  localparam int F_EMPTY = 0;
  localparam int F_TEMP  = 1;
  localparam int F_SAT   = 2;
  localparam int F_HW    = 3;
  localparam int F_SIM   = 4;
  localparam int F_TMO   = 5;
  localparam int F_WARN  = 6;
  localparam int N_FLAG  = 7;

  typedef enum logic [2:0] {
    U_ML = 3'h0, U_L = 3'h1, U_M3 = 3'h2, U_GALUS = 3'h3,
    U_GALUK = 3'h4, U_BARREL = 3'h5, U_USER = 3'h6
  } dsc_unit_e;

  typedef enum logic [2:0] {
    ST_STOP = 3'h1, ST_RUN = 3'h2, ST_DONE = 3'h4
  } dsc_state_e;

endpackage

/* File: dsc_meter_if.sv */
`timescale 1ns/1ns
interface dsc_meter_if;
  logic done;
  logic inWin;
  logic isLong;
  modport meter(output done, output inWin, output isLong);
  modport user(input done, input inWin, input isLong);
endinterface

/* File: dsc_hold_meter.sv */
`timescale 1ns/1ns
module dsc_hold_meter #(
  parameter logic [13:0] LO_MS   = 14'h0000,
  parameter logic [13:0] HI_MS   = 14'h0000,
  parameter logic [13:0] LONG_MS = 14'h0000
) (
  // Clock
  input wire logic       clk,
  input wire logic       resetN,
  input wire logic       ce,
  // Level to time
  input wire logic       msTick,
  input wire logic       level,
  // Result on release
  dsc_meter_if.meter     m
);

  logic        prev_r;
  logic [13:0] cnt_r;

  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      prev_r <= 1'b0;
      cnt_r  <= 14'h0000;
    end else if (ce) begin
      prev_r <= level;
      if (level && !prev_r) begin
        cnt_r <= 14'h0000;
      end else if (level && msTick && cnt_r != dsc_pkg::MS_SAT) begin
        cnt_r <= cnt_r + 14'h0001;
      end
    end
  end

  // Classified only at release so a held press never fires early
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      m.done   <= 1'b0;
      m.inWin  <= 1'b0;
      m.isLong <= 1'b0;
    end else if (ce) begin
      m.done   <= prev_r && !level;
      m.inWin  <= (cnt_r > LO_MS) && (cnt_r < HI_MS);
      m.isLong <= cnt_r > LONG_MS;
    end
  end

endmodule

/* File: dsc_status_mem.sv */
`timescale 1ns/1ns
module dsc_status_mem #(
  parameter int N = 7
) (
  // Clock
  input wire logic         clk,
  input wire logic         resetN,
  input wire logic         ce,
  // Sources and acknowledge
  input wire logic [N-1:0] setIn,
  input wire logic         clr,
  // Latched flags
  output logic [N-1:0]     flags
);

  // Set wins over clear, so a source still present is caught again
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      flags <= '0;
    end else if (ce) begin
      flags <= (flags & ~{N{clr}}) | setIn;
    end
  end

endmodule

/* File: dsc_dosing_ctrl.sv */
// What this block does
// - Pending messages make the status indicator alternate orange and red.
// - First status press opens the list; second acknowledges, clears, closes.
// - Errors still present after acknowledge are latched again and flash.
// - Status memory keeps seven separate flags: five sources, time-out and warning.
// - Dosing on: drive line is push-pull dosing output, control line input.
// - Dosing off: both lines off, then freely configurable.
// - Dosing softkeys act only after two seconds held and released.
// - Control pulse 0.5-4 s starts or stops; over 5 s resets when stopped.
// - Start drives output high and counts down while flow is present.
// - Stop interrupts dosing and keeps the count for resuming.
// - Softkey and control line can both stop.
// - Reset, only when finished or stopped, reloads the quantity.
// - Quantity has one decimal and is limited to 9999.9.
// - Unit selector has seven settings.
// - Count starts at quantity and halts at minus the correction.
// - Quantity plus correction not above zero warns and forces correction.
// - Zero flow during a run for the timeout raises time-out status.
// - Timeout adjustable from 0.5 to 10 seconds.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module dsc_dosing_ctrl #(
  parameter int MS_CYC = dsc_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        clkEn,
  // Avalon-MM slave
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest,
  // Softkeys
  input wire logic        startKey,
  input wire logic        stopKey,
  input wire logic        resetKey,
  input wire logic        statusKey,
  // Flow
  input wire logic        flowTick,
  input wire logic        flowNonZero,
  // Error sources
  input wire logic        errEmptyPipe,
  input wire logic        errTempCircuit,
  input wire logic        errFlowSat,
  input wire logic        errHardware,
  input wire logic        simActive,
  // Output lines
  input wire logic        remoteControlLineIn,
  output logic            remoteControlLineOut,
  output logic            remoteControlLineOe,
  output logic            dosingDriveLineOut,
  output logic            dosingDriveLineOe,
  // Indicator
  output logic            statusLit,
  output logic            statusRed,
  output logic            listOpen
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [11:0] pinS1_r;
  logic [11:0] pinS2_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinS1_r <= 12'h000;
      pinS2_r <= 12'h000;
    end else if (clkEn) begin
      pinS1_r <= {startKey, stopKey, resetKey, statusKey,
                  remoteControlLineIn, flowTick, flowNonZero,
                  simActive, errHardware, errFlowSat,
                  errTempCircuit, errEmptyPipe};
      pinS2_r <= pinS1_r;
    end
  end

  logic       sStart;
  logic       sStop;
  logic       sReset;
  logic       sStat;
  logic       sLine;
  logic       sTick;
  logic       sFlow;
  logic [4:0] sErr;

  assign sStart = pinS2_r[11];
  assign sStop  = pinS2_r[10];
  assign sReset = pinS2_r[9];
  assign sStat  = pinS2_r[8];
  assign sLine  = pinS2_r[7];
  assign sTick  = pinS2_r[6];
  assign sFlow  = pinS2_r[5];
  assign sErr   = pinS2_r[4:0];

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and edges

  logic [16:0] divCnt_r;
  logic        msTick_r;
  logic        tickPrev_r;
  logic        statPrev_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_r <= 17'h00000;
      msTick_r <= 1'b0;
    end else if (clkEn) begin
      msTick_r <= divCnt_r == 17'(MS_CYC - 1);
      divCnt_r <= (divCnt_r == 17'(MS_CYC - 1)) ? 17'h00000
                                                : divCnt_r + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickPrev_r <= 1'b0;
      statPrev_r <= 1'b0;
    end else if (clkEn) begin
      tickPrev_r <= sTick;
      statPrev_r <= sStat;
    end
  end

  logic flowEdge;
  assign flowEdge = sTick && !tickPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Press and pulse timing

  dsc_meter_if mStart ();
  dsc_meter_if mStop ();
  dsc_meter_if mReset ();
  dsc_meter_if mStat ();
  dsc_meter_if mLine ();

  localparam logic [13:0] KEY_LONG = 14'(dsc_pkg::KEY_HOLD_MS - 1);

  dsc_hold_meter #(.LONG_MS(KEY_LONG)) uStartKey (
    .clk(ref_clk), .resetN(reset_n), .ce(clkEn),
    .msTick(msTick_r), .level(sStart), .m(mStart)
  );
  dsc_hold_meter #(.LONG_MS(KEY_LONG)) uStopKey (
    .clk(ref_clk), .resetN(reset_n), .ce(clkEn),
    .msTick(msTick_r), .level(sStop), .m(mStop)
  );
  dsc_hold_meter #(.LONG_MS(KEY_LONG)) uResetKey (
    .clk(ref_clk), .resetN(reset_n), .ce(clkEn),
    .msTick(msTick_r), .level(sReset), .m(mReset)
  );
  dsc_hold_meter #(.LONG_MS(KEY_LONG)) uStatKey (
    .clk(ref_clk), .resetN(reset_n), .ce(clkEn),
    .msTick(msTick_r), .level(sStat), .m(mStat)
  );
  dsc_hold_meter #(
    .LO_MS(14'(dsc_pkg::CTL_MIN_MS)),
    .HI_MS(14'(dsc_pkg::CTL_MAX_MS)),
    .LONG_MS(14'(dsc_pkg::CTL_RST_MS))
  ) uLine (
    .clk(ref_clk), .resetN(reset_n), .ce(clkEn),
    .msTick(msTick_r), .level(sLine), .m(mLine)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Commands

  logic [4:0]          ctrl_r;
  dsc_pkg::dsc_state_e state_r;
  logic                dosEn;
  logic                keyStart;
  logic                keyStop;
  logic                keyReset;
  logic                lineMid;
  logic                lineLong;
  logic                doStart;
  logic                doStop;
  logic                doReset;

  assign dosEn    = ctrl_r[dsc_pkg::CTRL_DOS];
  assign keyStart = mStart.done && mStart.isLong;
  assign keyStop  = mStop.done && mStop.isLong;
  assign keyReset = mReset.done && mReset.isLong;
  assign lineMid  = dosEn && mLine.done && mLine.inWin;
  assign lineLong = dosEn && mLine.done && mLine.isLong;

  assign doStart = dosEn && state_r == dsc_pkg::ST_STOP && (keyStart || lineMid);
  assign doStop  = dosEn && state_r == dsc_pkg::ST_RUN && (keyStop || lineMid);
  // Long pulse while running falls through: no branch takes it
  assign doReset = dosEn && state_r != dsc_pkg::ST_RUN && (keyReset || lineLong);

  ////////////////////////////////////////////////////////////////////////////
  // Dosing counter and run state

  logic [16:0]        qty_r;
  logic [18:0]        corr_r;
  logic signed [19:0] count_r;
  logic signed [19:0] endVal;
  logic               atEnd;
  logic               nextEnd;

  assign endVal  = -$signed({corr_r[18], corr_r});
  assign atEnd   = count_r <= endVal;
  assign nextEnd = (count_r - 20'sd1) <= endVal;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= dsc_pkg::ST_STOP;
    end else if (clkEn) begin
      if (!dosEn) begin
        state_r <= dsc_pkg::ST_STOP;
      end else begin
        case (state_r)
          dsc_pkg::ST_STOP: begin
            if (doStart) begin
              state_r <= atEnd ? dsc_pkg::ST_DONE : dsc_pkg::ST_RUN;
            end
          end
          dsc_pkg::ST_RUN: begin
            if (doStop) begin
              state_r <= dsc_pkg::ST_STOP;
            end else if (flowEdge && nextEnd) begin
              state_r <= dsc_pkg::ST_DONE;
            end
          end
          dsc_pkg::ST_DONE: begin
            if (doReset) begin
              state_r <= dsc_pkg::ST_STOP;
            end
          end
          default: state_r <= dsc_pkg::ST_STOP;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 20'(dsc_pkg::QTY_RST);
    end else if (clkEn) begin
      if (doReset) begin
        count_r <= $signed({3'h0, qty_r});
      end else if (state_r == dsc_pkg::ST_RUN && flowEdge && !doStop) begin
        count_r <= count_r - 20'sd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow timeout

  logic [13:0] tmoCnt_r;
  logic [6:0]  tmo_r;
  logic        tmoHit;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tmoCnt_r <= 14'h0000;
    end else if (clkEn) begin
      if (state_r != dsc_pkg::ST_RUN || sFlow) begin
        tmoCnt_r <= 14'h0000;
      end else if (msTick_r && tmoCnt_r != dsc_pkg::MS_SAT) begin
        tmoCnt_r <= tmoCnt_r + 14'h0001;
      end
    end
  end

  assign tmoHit = state_r == dsc_pkg::ST_RUN && !sFlow &&
                  tmoCnt_r >= 14'(tmo_r) * 14'(dsc_pkg::DS_MS);

  ////////////////////////////////////////////////////////////////////////////
  // Status memory and indicator

  logic                       statPress;
  logic                       ack;
  logic                       warnSet;
  logic [dsc_pkg::N_FLAG-1:0] flags;
  logic [8:0]                 blinkCnt_r;

  // Outside dosing mode the status key acts on its plain press
  assign statPress = dosEn ? (mStat.done && mStat.isLong) : (sStat && !statPrev_r);
  assign ack       = statPress && listOpen;

  dsc_status_mem #(.N(dsc_pkg::N_FLAG)) uStatus (
    .clk(ref_clk),
    .resetN(reset_n),
    .ce(clkEn),
    .setIn({warnSet, tmoHit, sErr}),
    .clr(ack),
    .flags(flags)
  );

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      listOpen <= 1'b0;
    end else if (clkEn && statPress) begin
      listOpen <= !listOpen;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      blinkCnt_r <= 9'h000;
      statusLit  <= 1'b0;
      statusRed  <= 1'b0;
    end else if (clkEn) begin
      statusLit <= |flags;
      if (!(|flags)) begin
        blinkCnt_r <= 9'h000;
        statusRed  <= 1'b0;
      end else if (msTick_r) begin
        if (blinkCnt_r == 9'(dsc_pkg::BLINK_MS - 1)) begin
          blinkCnt_r <= 9'h000;
          statusRed  <= !statusRed;
        end else begin
          blinkCnt_r <= blinkCnt_r + 9'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output lines

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dosingDriveLineOut   <= 1'b0;
      dosingDriveLineOe    <= 1'b0;
      remoteControlLineOut <= 1'b0;
      remoteControlLineOe  <= 1'b0;
    end else if (clkEn) begin
      if (dosEn) begin
        dosingDriveLineOut   <= state_r == dsc_pkg::ST_RUN;
        dosingDriveLineOe    <= 1'b1;
        remoteControlLineOut <= 1'b0;
        remoteControlLineOe  <= 1'b0;
      end else begin
        dosingDriveLineOut   <= ctrl_r[dsc_pkg::CTRL_O2LV];
        dosingDriveLineOe    <= ctrl_r[dsc_pkg::CTRL_O2EN];
        remoteControlLineOut <= ctrl_r[dsc_pkg::CTRL_O1LV];
        remoteControlLineOe  <= ctrl_r[dsc_pkg::CTRL_O1EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, one wait cycle per access

  logic        req;
  logic        take;
  logic [31:0] wMerge;
  logic [31:0] oldVal;
  logic [31:0] rdMux;
  logic [2:0]  unit_r;
  logic        wrQty;
  logic        wrCorr;
  logic [16:0] qtyCand;
  logic [18:0] corrCand;
  logic signed [19:0] sum;
  logic signed [19:0] fixCorr;
  logic        sumBad;

  assign req  = avs_read || avs_write;
  assign take = req && !avs_waitrequest;

  always_comb begin
    oldVal = 32'h00000000;
    rdMux  = 32'h00000000;
    case (avs_address)
      dsc_pkg::A_CTRL:  rdMux = {27'h0, ctrl_r};
      dsc_pkg::A_QTY:   rdMux = {15'h0, qty_r};
      dsc_pkg::A_UNIT:  rdMux = {29'h0, unit_r};
      dsc_pkg::A_CORR:  rdMux = {{13{corr_r[18]}}, corr_r};
      dsc_pkg::A_TMO:   rdMux = {25'h0, tmo_r};
      dsc_pkg::A_COUNT: rdMux = {{12{count_r[19]}}, count_r};
      dsc_pkg::A_STAT:  rdMux = {16'h0, 1'b0, flags, 3'h0, listOpen,
                                 dosingDriveLineOut, state_r};
      default:          rdMux = 32'h00000000;
    endcase
    oldVal = rdMux;
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wMerge[8*b +: 8] = avs_byteenable[b] ? avs_writedata[8*b +: 8]
                                           : oldVal[8*b +: 8];
    end
  end

  assign wrQty    = take && avs_write && avs_address == dsc_pkg::A_QTY;
  assign wrCorr   = take && avs_write && avs_address == dsc_pkg::A_CORR;
  assign qtyCand  = !wrQty ? qty_r :
                    (wMerge > 32'(dsc_pkg::QTY_MAX)) ? dsc_pkg::QTY_MAX
                                                     : wMerge[16:0];
  assign corrCand = wrCorr ? wMerge[18:0] : corr_r;
  assign sum      = $signed({3'h0, qtyCand}) + $signed({corrCand[18], corrCand});
  assign sumBad   = sum <= 20'sd0;
  assign fixCorr  = 20'sd1 - $signed({3'h0, qtyCand});
  assign warnSet  = (wrQty || wrCorr) && sumBad;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (clkEn) begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest) begin
        avs_readdata <= avs_read ? rdMux : 32'h00000000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= dsc_pkg::CTRL_RST;
      unit_r <= dsc_pkg::U_L;
      tmo_r  <= dsc_pkg::TMO_RST;
      qty_r  <= dsc_pkg::QTY_RST;
      corr_r <= dsc_pkg::CORR_RST;
    end else if (clkEn) begin
      if (take && avs_write && avs_address == dsc_pkg::A_CTRL) begin
        ctrl_r <= wMerge[4:0];
      end
      if (take && avs_write && avs_address == dsc_pkg::A_UNIT &&
          wMerge <= 32'(dsc_pkg::U_USER)) begin
        unit_r <= wMerge[2:0];
      end
      if (take && avs_write && avs_address == dsc_pkg::A_TMO) begin
        tmo_r <= (wMerge < 32'(dsc_pkg::TMO_MIN)) ? dsc_pkg::TMO_MIN :
                 (wMerge > 32'(dsc_pkg::TMO_MAX)) ? dsc_pkg::TMO_MAX
                                                  : wMerge[6:0];
      end
      if (wrQty || wrCorr) begin
        qty_r  <= qtyCand;
        corr_r <= sumBad ? fixCorr[18:0] : corrCand;
      end
    end
  end

endmodule

/* File: dsc_dosing_ctrl_props.sv */
`timescale 1ns/1ns
module dsc_dosing_ctrl_props #(
  parameter int MS_CYC = 2
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Lines and indicator
  input wire logic        errHardware,
  input wire logic        remoteControlLineOe,
  input wire logic        dosingDriveLineOe,
  input wire logic        dosingDriveLineOut,
  input wire logic        statusLit,
  input wire logic        statusRed
);
  // Small margin for the ms divider phase
  localparam int BL = dsc_pkg::BLINK_MS * MS_CYC + 4;
  int redAge;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ctrl_wr;
    avs_write && !avs_waitrequest && avs_address == dsc_pkg::A_CTRL && avs_byteenable[0];
  endsequence
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      redAge <= 0;
    end else if (!statusLit || $changed(statusRed)) begin
      redAge <= 0;
    end else begin
      redAge <= redAge + 1;
    end
  end
  //////////////////////////////////////////
  chk_wait_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("request not answered");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  chk_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_write_zero: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data not zero on write");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_address > dsc_pkg::A_STAT |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_flag_lights: assert property ($rose(errHardware) |-> ##[1:6] statusLit)
    else $error("indicator not lit");
  chk_red_when_lit: assert property ($rose(statusRed) |-> statusLit)
    else $error("red while unlit");
  chk_blink_period: assert property (statusLit |-> redAge <= BL)
    else $error("indicator not blinking");
  chk_dosing_lines: assert property (s_ctrl_wr ##0 avs_writedata[0]
    |-> ##[1:3] dosingDriveLineOe && !remoteControlLineOe)
    else $error("dosing line roles wrong");
  chk_off_lines: assert property (s_ctrl_wr ##0 avs_writedata[4:0] == 5'h00
    |-> ##[1:3] !dosingDriveLineOe && !remoteControlLineOe && !dosingDriveLineOut)
    else $error("lines not off");
endmodule
bind dsc_dosing_ctrl dsc_dosing_ctrl_props #(.MS_CYC(MS_CYC)) dsc_dosing_ctrl_props_i (
  .ref_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .errHardware,
  .remoteControlLineOe, .dosingDriveLineOe, .dosingDriveLineOut, .statusLit, .statusRed
);

/* File: dsc_key_model.sv */
`timescale 1ns/1ns
module dsc_key_model #(
  parameter int MS_CYC = 2
) (
  // Clock
  input wire logic   clk,
  // Keys 0 start 1 stop 2 reset 3 status, then control line
  output logic [3:0] keys,
  output logic       ctlLevel
);
  // Idle line is strapped to ground, never left open
  initial begin
    keys = 4'h0;
    ctlLevel = 1'b0;
  end
  // Hold a key (k<4) or the control line (k=4) for ms, then release
  task automatic hold(input int k, input int ms);
    @(posedge clk);
    if (k < 4) begin
      keys[k] <= 1'b1;
    end else begin
      ctlLevel <= 1'b1;
    end
    repeat (ms * MS_CYC) @(posedge clk);
    keys <= 4'h0;
    ctlLevel <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* File: tb_dsc_dosing_ctrl.sv */
`timescale 1ns/1ns
module tb_dsc_dosing_ctrl;
  // Short ms keeps the two second holds affordable
  localparam int MSC = 2;
  logic        ref_clk, reset_n, avsRead, avsWrite, avsWaitrequest;
  logic        ctlLevel, ctlPin, flowTick, flowNonZero, ctlOut, ctlOe;
  logic        drvOut, drvOe, statusLit, statusRed, listOpen;
  logic [3:0]  keys;
  logic [4:0]  avsAddress, errSrc;
  logic [31:0] avsWritedata, avsReaddata, pins, q;
  int          errTotal = 0;
  int          compares = 0;
  int          cyc = 0;
  assign ctlPin = ctlOe ? ctlOut : ctlLevel;
  assign pins = {27'h0, listOpen, statusLit, ctlOe, drvOe, drvOut};
  dsc_dosing_ctrl #(.MS_CYC(MSC)) dsc_dosing_ctrl_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(4'hf), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .startKey(keys[0]), .stopKey(keys[1]), .resetKey(keys[2]), .statusKey(keys[3]),
    .flowTick(flowTick), .flowNonZero(flowNonZero), .errEmptyPipe(errSrc[0]),
    .errTempCircuit(errSrc[1]), .errFlowSat(errSrc[2]), .errHardware(errSrc[3]),
    .simActive(errSrc[4]), .remoteControlLineIn(ctlPin), .remoteControlLineOut(ctlOut),
    .remoteControlLineOe(ctlOe), .dosingDriveLineOut(drvOut), .dosingDriveLineOe(drvOe),
    .statusLit(statusLit), .statusRed(statusRed), .listOpen(listOpen));
  dsc_key_model #(.MS_CYC(MSC)) dsc_key_model_i (.clk(ref_clk), .keys(keys), .ctlLevel(ctlLevel));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////
  task automatic finishTest();
    if (errTotal == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    do begin
      @(posedge ref_clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic key(input int k, input int ms);
    dsc_key_model_i.hold(k, ms);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      flowTick <= 1'b1;
      wt(4);
      flowTick <= 1'b0;
      wt(4);
    end
  endtask
  //////////////////////////////////////////
  task automatic t_regs();
    rdc(dsc_pkg::A_QTY, 32'h64);
    rdc(dsc_pkg::A_TMO, 32'ha);
    rdc(dsc_pkg::A_COUNT, 32'h64);
    rdc(5'h1c, 32'h0);
    for (int u = 0; u < 8; u++) begin
      wr(dsc_pkg::A_UNIT, 32'(u));
      rdc(dsc_pkg::A_UNIT, (u < 7) ? 32'(u) : 32'h6);
    end
    wr(dsc_pkg::A_QTY, 32'h1ffff);
    rdc(dsc_pkg::A_QTY, 32'h1869f);
    wr(dsc_pkg::A_QTY, 32'h64);
    wr(dsc_pkg::A_TMO, 32'h1);
    rdc(dsc_pkg::A_TMO, 32'h5);
    wr(dsc_pkg::A_TMO, 32'h7f);
    rdc(dsc_pkg::A_TMO, 32'h64);
  endtask
  task automatic t_dose();
    wr(dsc_pkg::A_CTRL, 32'h1);
    wt(4);
    chk(pins, 32'h2);
    key(4, 1000);
    chk(pins, 32'h3);
    tick(5);
    rdc(dsc_pkg::A_COUNT, 32'h5f);
    key(4, 5100);
    key(1, 500);
    rdc(dsc_pkg::A_STAT, 32'ha);
    key(1, 2100);
    chk(pins, 32'h2);
    rdc(dsc_pkg::A_COUNT, 32'h5f);
    key(0, 2100);
    rdc(dsc_pkg::A_STAT, 32'ha);
    key(4, 1000);
    rdc(dsc_pkg::A_STAT, 32'h1);
    key(4, 5100);
    rdc(dsc_pkg::A_COUNT, 32'h64);
  endtask
  task automatic t_corr();
    wr(dsc_pkg::A_QTY, 32'ha);
    wr(dsc_pkg::A_CORR, 32'hfffffff6);
    rdc(dsc_pkg::A_CORR, 32'hfffffff7);
    rdc(dsc_pkg::A_STAT, 32'h4001);
    key(2, 2100);
    key(0, 2100);
    tick(1);
    rdc(dsc_pkg::A_STAT, 32'h4004);
    tick(1);
    rdc(dsc_pkg::A_COUNT, 32'h9);
  endtask
  task automatic t_tmo();
    wr(dsc_pkg::A_TMO, 32'h5);
    key(2, 2100);
    flowNonZero <= 1'b0;
    key(0, 2100);
    wt(400 * MSC);
    rdc(dsc_pkg::A_STAT, 32'h400a);
    wt(200 * MSC);
    rdc(dsc_pkg::A_STAT, 32'h600a);
    key(1, 2100);
    flowNonZero <= 1'b1;
  endtask
  task automatic t_status();
    int n;
    logic r;
    wr(dsc_pkg::A_CTRL, 32'h0);
    wt(4);
    chk(pins, 32'h8);
    wr(dsc_pkg::A_CTRL, 32'h1e);
    wt(4);
    chk(32'({ctlOut, pins[2:0]}), 32'hf);
    wr(dsc_pkg::A_CTRL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      r = statusRed;
      while (statusRed === r && n < 2000) begin
        wt(1);
        n++;
      end
    end
    chk(32'(n), 32'(dsc_pkg::BLINK_MS * MSC));
    key(3, 5);
    chk(pins, 32'h18);
    key(3, 5);
    chk(pins, 32'h0);
    for (int i = 0; i < 5; i++) begin
      errSrc <= 5'(1 << i);
      wt(8);
      errSrc <= 5'h0;
      key(3, 5);
      rdc(dsc_pkg::A_STAT, 32'h11 | (32'h100 << i));
      key(3, 5);
      chk(pins, 32'h0);
    end
    errSrc <= 5'h8;
    key(3, 5);
    key(3, 5);
    rdc(dsc_pkg::A_STAT, 32'h801);
    chk(pins, 32'h8);
    errSrc <= 5'h0;
  endtask
  //////////////////////////////////////////
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errTotal++;
      finishTest();
    end
  end
  initial begin
    reset_n = 1'b0;
    avsAddress = 5'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0;
    flowTick = 1'b0;
    flowNonZero = 1'b1;
    errSrc = 5'h0;
    wt(20);
    reset_n <= 1'b1;
    t_regs();
    t_dose();
    t_corr();
    t_tmo();
    t_status();
    finishTest();
  end
endmodule
